// ### core/cfg_port_map.svh
// Field widths and timing counts for the configuration port
`ifndef CFG_PORT_MAP_SVH
`define CFG_PORT_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CFG_DATA_W        8
`define CFG_ADDR_W        18
`define CFG_MODE_W        3
`define CFG_OPT_W         4
`define CFG_FIFO_DEPTH    16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFG_CLK_PERIOD_NS 50
`define CFG_ROM_ACCESS_NS 150
`define CFG_ROM_CYCLES \
    ((`CFG_ROM_ACCESS_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_ROM_CNT_W     4

`endif

// ### core/cfg_port_pkg.sv
// Types shared by the configuration port modules
package cfg_port_pkg;

    // ------------------------------------------------------------
    // Configuration modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_MASTER_PAR  = 3'h0,
        MODE_ASYNC_PERIPH = 3'h1,
        MODE_SLAVE_PAR   = 3'h2,
        MODE_HOST_BURST  = 3'h3,
        MODE_HOST_PLAIN  = 3'h4,
        MODE_SERIAL      = 3'h5
    } mode_e;

    // ------------------------------------------------------------
    // End-of-configuration sequence, Gray coded
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CONFIG  = 2'h0,
        ST_RELEASE = 2'h1,
        ST_USER    = 2'h3
    } phase_e;

endpackage

// ### core/cfg_fifo_if.sv
// Valid/ready carrier between the port and its byte FIFO
`timescale 1ns/1ps
interface cfg_fifo_if #(
    parameter int WIDTH = 8
);
    logic             fill_valid;
    logic             fill_ready;
    logic [WIDTH-1:0] fill_data;
    logic             drain_valid;
    logic             drain_ready;
    logic [WIDTH-1:0] drain_data;

    modport fifo (
        input  fill_valid, fill_data, drain_ready,
        output fill_ready, drain_valid, drain_data
    );
    modport user (
        output fill_valid, fill_data, drain_ready,
        input  fill_ready, drain_valid, drain_data
    );
endinterface

// ### core/cfg_fifo.sv
// Byte FIFO with registered read data
`timescale 1ns/1ps
module cfg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    cfg_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic [WIDTH-1:0]            out;
        logic                        out_v;
    } fifo_s;

    fifo_s st;
    fifo_s next_st;
    logic  push;
    logic  pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        port.fill_ready  = (st.cnt != (AW+1)'(DEPTH));
        port.drain_valid = st.out_v;
        port.drain_data  = st.out;
        push = port.fill_valid && port.fill_ready;
        pop  = (st.cnt != '0) && (!st.out_v || port.drain_ready);
        if (port.drain_ready && st.out_v) begin
            next_st.out_v = 1'b0;
        end
        if (pop) begin
            next_st.out   = st.mem[st.rd];
            next_st.out_v = 1'b1;
            next_st.rd    = st.rd + 1'b1;
        end
        if (push) begin
            next_st.mem[st.wr] = port.fill_data;
            next_st.wr         = st.wr + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // cfg_fifo

// ### core/async_peripheral_config_port.sv
// Byte-wide configuration loading port of the device
`timescale 1ns/1ps
`include "cfg_port_map.svh"

module async_peripheral_config_port #(
    parameter int DATA_W     = `CFG_DATA_W,
    parameter int ADDR_W     = `CFG_ADDR_W,
    parameter int FIFO_DEPTH = `CFG_FIFO_DEPTH
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic [`CFG_MODE_W-1:0] cfg_mode,
    input  wire logic                   config_end,
    input  wire logic [`CFG_OPT_W-1:0]  done_opt,
    input  wire logic [`CFG_OPT_W-1:0]  io_opt,
    input  wire logic                   host_port_keep,
    input  wire logic                   select_low_input,
    input  wire logic                   select_high_input,
    input  wire logic                   read_strobe_n,
    input  wire logic                   write_strobe_n,
    input  wire logic [DATA_W-1:0]      data_in,
    input  wire logic                   cfg_byte_ready,
    output logic                        status_bit_seven,
    output logic                        status_bit_seven_oe_n,
    output logic                        data_pullup_en,
    output logic                        select_pullup_en,
    output logic [ADDR_W-1:0]           addr_out,
    output logic                        addr_oe_n,
    output logic                        addr_pullup_en,
    output logic                        ready_out,
    output logic                        host_interrupt_n,
    output logic                        burst_inhibit_out,
    output logic [DATA_W-1:0]           cfg_byte,
    output logic                        cfg_byte_valid,
    output logic                        done_release,
    output logic                        user_io_active
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                      sl_m;
        logic                      sl_s;
        logic                      sh_m;
        logic                      sh_s;
        logic                      rd_m;
        logic                      rd_s;
        logic                      rd_d;
        logic                      wr_m;
        logic                      wr_s;
        logic                      wr_d;
        logic [DATA_W-1:0]         hold;
        logic                      hold_v;
        logic [`CFG_ROM_CNT_W-1:0] rom_cnt;
        logic                      irq_pend;
        cfg_port_pkg::phase_e      phase;
        logic [`CFG_OPT_W-1:0]     tmr;
        logic                      stat;
        logic                      stat_oe_n;
        logic                      data_pu;
        logic                      sel_pu;
        logic [ADDR_W-1:0]         addr;
        logic                      addr_oe_n;
        logic                      addr_pu;
        logic                      ready;
        logic                      irq_n;
        logic                      bi;
        logic                      done;
        logic                      user_io;
    } port_s;

    port_s                st;
    port_s                next_st;
    cfg_port_pkg::mode_e  mode;
    logic                 selected;
    logic                 sel_mode;
    logic                 periph;
    logic                 host;
    logic                 cfg_on;
    logic                 wr_fall;
    logic                 rd_fall;
    logic                 capture;
    logic                 rom_take;
    logic                 moved;

    cfg_fifo_if #(.WIDTH(DATA_W)) fifo_bus ();

    // Deep buffer lets the loader absorb stalls of configuration memory
    cfg_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .port    (fifo_bus.fifo)
    );

    assign mode = cfg_port_pkg::mode_e'(cfg_mode);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Two-flop synchronisers, third stage only for edges
        next_st.sl_m = select_low_input;
        next_st.sl_s = st.sl_m;
        next_st.sh_m = select_high_input;
        next_st.sh_s = st.sh_m;
        next_st.rd_m = read_strobe_n;
        next_st.rd_s = st.rd_m;
        next_st.rd_d = st.rd_s;
        next_st.wr_m = write_strobe_n;
        next_st.wr_s = st.wr_m;
        next_st.wr_d = st.wr_s;

        cfg_on   = (st.phase != cfg_port_pkg::ST_USER) && !st.user_io;
        periph   = (mode == cfg_port_pkg::MODE_ASYNC_PERIPH);
        host     = (mode == cfg_port_pkg::MODE_HOST_BURST) ||
                   (mode == cfg_port_pkg::MODE_HOST_PLAIN);
        sel_mode = periph || host ||
                   (mode == cfg_port_pkg::MODE_SLAVE_PAR);
        selected = !st.sl_s && st.sh_s && sel_mode;

        // Falling edges: one pulse gives exactly one event
        wr_fall = st.wr_d && !st.wr_s;
        rd_fall = st.rd_d && !st.rd_s;

        // ------------------------------------------------------------
        // Byte capture into the holding buffer
        // ------------------------------------------------------------
        // A write while busy is dropped; the host must poll status first
        capture = cfg_on && selected && wr_fall && !st.hold_v &&
                  (periph || (mode == cfg_port_pkg::MODE_SLAVE_PAR));
        if (capture) begin
            next_st.hold   = data_in;
            next_st.hold_v = 1'b1;
        end

        // ------------------------------------------------------------
        // Master parallel ROM stepping
        // ------------------------------------------------------------
        rom_take = 1'b0;
        if (cfg_on && (mode == cfg_port_pkg::MODE_MASTER_PAR)) begin
            if (st.rom_cnt != '0) begin
                next_st.rom_cnt = st.rom_cnt - 1'b1;
            end else if (!st.hold_v) begin
                rom_take        = 1'b1;
                next_st.hold    = data_in;
                next_st.hold_v  = 1'b1;
                next_st.addr    = st.addr + 1'b1;
                next_st.rom_cnt = `CFG_ROM_CNT_W'(`CFG_ROM_CYCLES);
            end
        end

        // ------------------------------------------------------------
        // Buffer to FIFO; busy until the byte has left
        // ------------------------------------------------------------
        fifo_bus.fill_valid  = st.hold_v;
        fifo_bus.fill_data   = st.hold;
        fifo_bus.drain_ready = cfg_byte_ready;
        moved = st.hold_v && fifo_bus.fill_ready;
        if (moved) begin
            next_st.hold_v = 1'b0;
        end

        next_st.ready = cfg_on && periph &&
                        !next_st.hold_v;
        next_st.stat  = next_st.ready;

        // Write wins when both strobes are low
        next_st.stat_oe_n = !(cfg_on && periph && selected &&
                              !st.rd_s && st.wr_s);

        // ------------------------------------------------------------
        // Pin conditioning during configuration
        // ------------------------------------------------------------
        next_st.sel_pu  = cfg_on;
        next_st.data_pu = cfg_on &&
                          (periph ||
                           (mode == cfg_port_pkg::MODE_MASTER_PAR) ||
                           (mode == cfg_port_pkg::MODE_SLAVE_PAR));
        if (cfg_on && (mode == cfg_port_pkg::MODE_MASTER_PAR)) begin
            next_st.addr_oe_n = 1'b0;
            next_st.addr_pu   = 1'b0;
        end else if (cfg_on && !host) begin
            next_st.addr_oe_n = 1'b1;
            next_st.addr_pu   = 1'b1;
        end else begin
            next_st.addr_oe_n = 1'b1;
            next_st.addr_pu   = 1'b0;
        end

        // ------------------------------------------------------------
        // Host port pins
        // ------------------------------------------------------------
        // Pending is raised at end of configuration; set beats clear
        if (host && rd_fall && selected) begin
            next_st.irq_pend = 1'b0;
        end
        if (host && config_end && (st.phase == cfg_port_pkg::ST_CONFIG))
        begin
            next_st.irq_pend = 1'b1;
        end
        if (host && (cfg_on || host_port_keep)) begin
            next_st.irq_n = !next_st.irq_pend;
            next_st.bi    =
                (mode == cfg_port_pkg::MODE_HOST_BURST);
        end else begin
            next_st.irq_n = 1'b1;
            next_st.bi    = 1'b0;
        end

        // ------------------------------------------------------------
        // End of configuration: two independent release times
        // ------------------------------------------------------------
        case (st.phase)
            cfg_port_pkg::ST_CONFIG: begin
                next_st.tmr = '0;
                if (config_end) begin
                    next_st.phase = cfg_port_pkg::ST_RELEASE;
                end
            end
            cfg_port_pkg::ST_RELEASE: begin
                if (st.tmr >= done_opt) begin
                    next_st.done = 1'b1;
                end
                if (st.tmr >= io_opt) begin
                    next_st.user_io = 1'b1;
                end
                if (next_st.done && next_st.user_io) begin
                    next_st.phase = cfg_port_pkg::ST_USER;
                end else if (st.tmr != '1) begin
                    next_st.tmr = st.tmr + 1'b1;
                end
            end
            cfg_port_pkg::ST_USER: begin
                next_st.done    = 1'b1;
                next_st.user_io = 1'b1;
            end
            default: begin
                next_st.phase = cfg_port_pkg::ST_CONFIG;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Strobe flops idle high so reset release never looks like an edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st           <= '0;
            st.sl_m      <= 1'b1;
            st.sl_s      <= 1'b1;
            st.rd_m      <= 1'b1;
            st.rd_s      <= 1'b1;
            st.rd_d      <= 1'b1;
            st.wr_m      <= 1'b1;
            st.wr_s      <= 1'b1;
            st.wr_d      <= 1'b1;
            st.phase     <= cfg_port_pkg::ST_CONFIG;
            st.stat_oe_n <= 1'b1;
            st.addr_oe_n <= 1'b1;
            st.irq_n     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign status_bit_seven      = st.stat;
    assign status_bit_seven_oe_n = st.stat_oe_n;
    assign data_pullup_en        = st.data_pu;
    assign select_pullup_en      = st.sel_pu;
    assign addr_out              = st.addr;
    assign addr_oe_n             = st.addr_oe_n;
    assign addr_pullup_en        = st.addr_pu;
    assign ready_out             = st.ready;
    assign host_interrupt_n      = st.irq_n;
    assign burst_inhibit_out     = st.bi;
    assign cfg_byte              = fifo_bus.drain_data;
    assign cfg_byte_valid        = fifo_bus.drain_valid;
    assign done_release          = st.done;
    assign user_io_active        = st.user_io;

endmodule // async_peripheral_config_port

// ### verification/cfg_host_model.sv
// Host partner that writes configuration bytes and polls status
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic ref_clk,
    input  wire logic ready_out,
    output logic      select_low_input,
    output logic      select_high_input,
    output logic      read_strobe_n,
    output logic      write_strobe_n,
    output logic [7:0] data_in
);
    // ----------------------------------------------------------------
    // Host transfers
    // ----------------------------------------------------------------
    initial begin
        select_low_input = 1'b1;
        select_high_input = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        data_in = 8'hFF;
    end
    task automatic sel(input logic on);
        @(posedge ref_clk);
        select_low_input <= !on;
        select_high_input <= on;
    endtask
    // Gives up polling after a bound, so a busy device sees a refused write
    task automatic write_byte(input logic [7:0] b, input logic rd);
        int n;
        for (n = 0; n < 200 && ready_out !== 1'b1; n++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        data_in <= b;
        write_strobe_n <= 1'b0;
        read_strobe_n <= !rd;
        repeat (3) @(posedge ref_clk);
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        data_in <= 8'hFF; // Released pins float to their pull-ups
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic strobe_read(input int len);
        @(posedge ref_clk);
        read_strobe_n <= 1'b0;
        repeat (len) @(posedge ref_clk);
        read_strobe_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // cfg_host_model

// ### verification/async_peripheral_config_port_chk.sv
// Port checker for the configuration loading port
`timescale 1ns/1ps
`include "cfg_port_map.svh"
module async_peripheral_config_port_chk #(
    parameter int DATA_W = 8
) (
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic [`CFG_MODE_W-1:0] cfg_mode,
    input wire logic                   config_end,
    input wire logic                   write_strobe_n,
    input wire logic                   cfg_byte_ready,
    input wire logic                   status_bit_seven,
    input wire logic                   status_bit_seven_oe_n,
    input wire logic                   select_pullup_en,
    input wire logic                   addr_oe_n,
    input wire logic                   addr_pullup_en,
    input wire logic                   ready_out,
    input wire logic                   host_interrupt_n,
    input wire logic                   burst_inhibit_out,
    input wire logic [DATA_W-1:0]      cfg_byte,
    input wire logic                   cfg_byte_valid,
    input wire logic                   done_release
);
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    status_mode_a: assert property (!status_bit_seven_oe_n |->
        cfg_mode == 3'h1) else $error("status driven outside peripheral");
    status_match_a: assert property (!status_bit_seven_oe_n |->
        status_bit_seven == ready_out) else $error("status not ready");
    addr_drive_a: assert property (!addr_oe_n |->
        cfg_mode == 3'h0) else $error("address driven in wrong mode");
    addr_pullup_a: assert property (addr_pullup_en |-> addr_oe_n &&
        cfg_mode inside {3'h1, 3'h2, 3'h5}) else $error("address pull-up");
    burst_mode_a: assert property (burst_inhibit_out |->
        cfg_mode == 3'h3) else $error("burst inhibit in wrong mode");
    irq_mode_a: assert property (!host_interrupt_n |->
        cfg_mode inside {3'h3, 3'h4}) else $error("interrupt in wrong mode");
    ready_cause_a: assert property ($fell(ready_out) && !config_end |->
        !$past(write_strobe_n, 3)) else $error("busy without write");
    ready_back_a: assert property ($fell(ready_out) |->
        ##[1:600] (ready_out || config_end)) else $error("busy stuck");
    byte_hold_a: assert property (cfg_byte_valid && !cfg_byte_ready |=>
        cfg_byte_valid && $stable(cfg_byte)) else $error("byte dropped");
    done_stays_a: assert property (done_release |=>
        done_release) else $error("done released then withdrawn");
    select_release_a: assert property (done_release &&
        config_end |-> ##[0:40] !select_pullup_en) else $error("pull-up kept");
endmodule // async_peripheral_config_port_chk

bind async_peripheral_config_port async_peripheral_config_port_chk #(
    .DATA_W(DATA_W)
) u_async_peripheral_config_port_chk (
    .ref_clk, .sys_rst, .cfg_mode, .config_end, .write_strobe_n,
    .cfg_byte_ready, .status_bit_seven, .status_bit_seven_oe_n,
    .select_pullup_en, .addr_oe_n, .addr_pullup_en, .ready_out,
    .host_interrupt_n, .burst_inhibit_out, .cfg_byte, .cfg_byte_valid,
    .done_release
);

// ### verification/async_peripheral_config_port_tb_top.sv
// Self-checking bench for the configuration loading port
`timescale 1ns/1ps
module async_peripheral_config_port_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  cfg_mode = 3'h1;
    logic        config_end = 1'b0;
    logic [3:0]  done_opt = 4'h2;
    logic [3:0]  io_opt = 4'h6;
    logic        host_port_keep = 1'b0;
    logic        cfg_byte_ready = 1'b1;
    logic        select_low_input, select_high_input, read_strobe_n;
    logic        write_strobe_n, status_bit_seven, status_bit_seven_oe_n;
    logic        data_pullup_en, select_pullup_en, addr_oe_n, addr_pullup_en;
    logic        ready_out, host_interrupt_n, burst_inhibit_out, oe_seen;
    logic        cfg_byte_valid, done_release, user_io_active;
    logic [7:0]  data_in, cfg_byte;
    logic [17:0] addr_out;
    logic [7:0]  got[$];
    int          num_errors = 0;
    int          n_tests = 0;

    async_peripheral_config_port u_async_peripheral_config_port (
        .ref_clk, .sys_rst, .cfg_mode, .config_end, .done_opt, .io_opt,
        .host_port_keep, .select_low_input, .select_high_input,
        .read_strobe_n, .write_strobe_n, .data_in, .cfg_byte_ready,
        .status_bit_seven, .status_bit_seven_oe_n, .data_pullup_en,
        .select_pullup_en, .addr_out, .addr_oe_n, .addr_pullup_en,
        .ready_out, .host_interrupt_n, .burst_inhibit_out, .cfg_byte,
        .cfg_byte_valid, .done_release, .user_io_active
    );
    cfg_host_model u_cfg_host_model (
        .ref_clk, .ready_out, .select_low_input, .select_high_input,
        .read_strobe_n, .write_strobe_n, .data_in
    );

    // ----------------------------------------------------------------
    // Clock, sink log and shared tasks
    // ----------------------------------------------------------------
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (cfg_byte_valid === 1'b1 && cfg_byte_ready === 1'b1)
            got.push_back(cfg_byte);
        if (status_bit_seven_oe_n === 1'b0)
            oe_seen <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] m);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        cfg_mode <= m;
        config_end <= 1'b0;
        host_port_keep <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(addr_oe_n, 1, "reset addr");
        check(host_interrupt_n, 1, "reset irq");
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        got.delete();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fill;
        do_reset(3'h1);
        cfg_byte_ready <= 1'b0;
        u_cfg_host_model.sel(1'b1);
        @(negedge ref_clk);
        check(select_pullup_en, 1, "select pu");
        check(data_pullup_en, 1, "data pu");
        check(ready_out, 1, "idle ready");
        for (int i = 0; i < 19; i++)
            u_cfg_host_model.write_byte(8'(8'h30 + i), 1'b0);
        @(negedge ref_clk);
        check(ready_out, 0, "full busy");
        @(posedge ref_clk);
        cfg_byte_ready <= 1'b1;
        repeat (40) @(negedge ref_clk);
        check(got.size(), 18, "byte count");
        for (int i = 0; i < 18; i++)
            check(got[i], 8'h30 + i, "byte order");
    endtask
    task automatic t_status;
        do_reset(3'h1);
        u_cfg_host_model.sel(1'b0);
        oe_seen = 1'b0;
        u_cfg_host_model.write_byte(8'hA5, 1'b0);
        u_cfg_host_model.strobe_read(4);
        @(negedge ref_clk);
        check(got.size(), 0, "unselected write");
        check(oe_seen, 0, "unselected read");
        u_cfg_host_model.sel(1'b1);
        fork
            u_cfg_host_model.strobe_read(4);
            begin
                repeat (6) @(negedge ref_clk);
                check(status_bit_seven_oe_n, 0, "status oe");
                check(status_bit_seven, 1, "status ready");
            end
        join
        oe_seen = 1'b0;
        u_cfg_host_model.write_byte(8'h5A, 1'b1);
        repeat (10) @(negedge ref_clk);
        check(oe_seen, 0, "both strobes");
        check(got[0], 8'h5A, "write wins");
    endtask
    task automatic t_modes;
        logic [17:0] a0;
        for (int m = 0; m < 6; m++) begin
            do_reset(3'(m));
            @(negedge ref_clk);
            check(burst_inhibit_out, m == 3, "burst");
            check(addr_oe_n, m != 0, "addr oe");
            check(addr_pullup_en, m inside {1, 2, 5}, "addr pu");
            a0 = addr_out;
            oe_seen = 1'b0;
            u_cfg_host_model.write_byte(8'(m), 1'b0);
            u_cfg_host_model.strobe_read(4);
            @(negedge ref_clk);
            if (m == 0) begin
                check(addr_out - a0 > 2, 1, "rom step");
                check(got[0], 8'hFF, "rom data");
            end else
                check(got.size(), m inside {1, 2}, "mode write");
            check(oe_seen, m == 1, "mode status");
            if (m inside {3, 4}) begin
                @(posedge ref_clk);
                host_port_keep <= 1'b1;
                config_end <= 1'b1;
                repeat (3) @(negedge ref_clk);
                check(host_interrupt_n, 0, "irq set");
                u_cfg_host_model.strobe_read(3);
                @(negedge ref_clk);
                check(host_interrupt_n, 1, "irq clear");
                check(burst_inhibit_out, m == 3, "port kept");
            end
        end
    endtask
    task automatic t_release;
        int n;
        do_reset(3'h1);
        done_opt <= 4'h1;
        io_opt <= 4'h5;
        config_end <= 1'b1;
        for (n = 0; n < 60 && done_release !== 1'b1; n++)
            @(negedge ref_clk);
        check(user_io_active, 0, "io early");
        for (n = 0; n < 60 && user_io_active !== 1'b1; n++)
            @(negedge ref_clk);
        check(n, 4, "release gap");
        @(negedge ref_clk);
        check(select_pullup_en, 0, "pins freed");
        u_cfg_host_model.write_byte(8'h77, 1'b0);
        @(negedge ref_clk);
        check(got.size(), 0, "user phase");
    endtask

    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end
    initial begin
        t_fill();
        t_status();
        t_modes();
        t_release();
        end_of_test();
    end
endmodule // async_peripheral_config_port_tb_top
